// ---- hdl/tlc_pkg.sv ----
package tlc_pkg;

    // register byte offsets on the apb bus
    localparam logic [7:0] OFS_CMD    = 8'h00;
    localparam logic [7:0] OFS_MODE   = 8'h04;
    localparam logic [7:0] OFS_STATUS = 8'h08;
    localparam logic [7:0] OFS_VECTOR = 8'h0c;

    // select commands written to the command register
    typedef enum logic [3:0] {
        CMD_ECHO      = 4'h0,
        CMD_KEYBOARD  = 4'h1,
        CMD_STEP      = 4'h2,
        CMD_CONT      = 4'h3,
        CMD_INIT      = 4'h4,
        CMD_WORD_EN   = 4'h5,
        CMD_EOB_EN    = 4'h6,
        CMD_IRQ_OFF   = 4'h7,
        CMD_MOTOR_ON  = 4'h8,
        CMD_MOTOR_OFF = 4'h9
    } tlc_cmd_t;

    // transfer direction in half duplex
    typedef enum logic {
        DIR_WRITE = 1'b0,
        DIR_READ  = 1'b1
    } tlc_dir_t;

    // paper tape reader control
    typedef enum logic [1:0] {
        RDR_IDLE = 2'b00,
        RDR_STEP = 2'b01,
        RDR_CONT = 2'b10
    } tlc_rdr_t;

    // status register bit positions
    localparam int ST_BUF_READY = 0;
    localparam int ST_WORD_MASK = 1;
    localparam int ST_NOT_BUSY  = 2;
    localparam int ST_CTS       = 3;
    localparam int ST_MOTOR_ON  = 4;
    localparam int ST_FULL_DUP  = 5;
    localparam int ST_BLANK     = 6;
    localparam int ST_ECHO      = 7;
    localparam int ST_READ_MODE = 8;
    localparam int ST_READER    = 9;
    localparam int ST_EOB_MASK  = 10;

    // interrupt vector locations
    localparam logic [15:0] VEC_WORD   = 16'h0002;
    localparam logic [15:0] VEC_EOB    = 16'h0006;
    localparam logic [15:0] VEC_ALT    = 16'h0020;
    localparam logic [15:0] VEC_OFFSET = 16'h0100;

    // values after reset
    localparam logic RST_MOTOR_ON = 1'b1;

    // motor spin-up blanking time
    localparam int BLANK_TIME_MS = 600;
    localparam int CLK_KHZ       = 100000;
    localparam int BLANK_CYCLES  = BLANK_TIME_MS * CLK_KHZ;

endpackage

// ---- hdl/tlc_ctl_if.sv ----
`timescale 1ns/100ps
interface tlc_ctl_if;
    logic        blank_load;
    logic        bypass_n;
    logic        blank_active;
    logic        word_mask;
    logic        eob_mask;
    logic        int_enable;
    logic        buffer_ready;
    logic        echo_in;
    logic        word_ack;
    logic        eob_ack;
    logic        full_duplex;
    logic        alt_jumper;
    logic        offset_jumper;
    logic        word_irq;
    logic        eob_irq;
    logic [15:0] word_vector;
    logic [15:0] eob_vector;

    modport ctl (
        output blank_load, bypass_n, word_mask, eob_mask, int_enable, buffer_ready,
        output echo_in, word_ack, eob_ack, full_duplex, alt_jumper, offset_jumper,
        input  blank_active, word_irq, eob_irq, word_vector, eob_vector
    );
    modport timer (
        input  blank_load, bypass_n,
        output blank_active
    );
    modport irq (
        input  blank_active, word_mask, eob_mask, int_enable, buffer_ready, echo_in,
        input  word_ack, eob_ack, full_duplex, alt_jumper, offset_jumper,
        output word_irq, eob_irq, word_vector, eob_vector
    );
endinterface

// ---- hdl/tlc_blank_timer.sv ----
`timescale 1ns/100ps
module tlc_blank_timer #(
    parameter int unsigned CYCLES = tlc_pkg::BLANK_CYCLES
) (
    input  wire logic pclk,
    input  wire logic presetn,
    tlc_ctl_if.timer  bus
);
    localparam int CW = $clog2(CYCLES + 1);
    localparam logic [CW-1:0] LOAD_VAL = CW'(CYCLES);

    logic [CW-1:0] cnt;
    logic [CW-1:0] next_cnt;

    // reload on motor-on, count down to zero, bypass kills it
    always_comb begin
        next_cnt = cnt;
        if (!bus.bypass_n) begin
            next_cnt = '0;
        end else if (bus.blank_load) begin
            next_cnt = LOAD_VAL;
        end else if (cnt != '0) begin
            next_cnt = cnt - CW'(1);
        end
    end

    // counter on the system clock
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cnt <= '0;
        end else begin
            cnt <= next_cnt;
        end
    end

    // blanking flag follows the counter
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            bus.blank_active <= 1'b0;
        end else begin
            bus.blank_active <= (next_cnt != '0);
        end
    end

    property p_blank_start;
        @(posedge pclk) disable iff (!presetn)
        bus.blank_load && bus.bypass_n ##1 bus.bypass_n |-> bus.blank_active ##1 bus.blank_active;
    endproperty
    a_blank_start: assert property (p_blank_start) else $error("blanking not started");

    property p_bypass;
        @(posedge pclk) disable iff (!presetn)
        !bus.bypass_n |=> !bus.blank_active;
    endproperty
    a_bypass: assert property (p_bypass) else $error("blanking despite bypass");

endmodule // tlc_blank_timer

// ---- hdl/tlc_irq_unit.sv ----
`timescale 1ns/100ps
module tlc_irq_unit (
    input  wire logic pclk,
    input  wire logic presetn,
    tlc_ctl_if.irq    bus
);
    logic word_cond;
    logic eob_cond;
    logic alt_sel;
    logic [15:0] base_ofs;

    // request conditions, muted while the motor blanking runs
    assign word_cond = bus.word_mask && bus.int_enable && bus.buffer_ready
                       && !bus.blank_active;
    assign eob_cond  = bus.eob_mask && bus.int_enable && bus.echo_in
                       && !bus.blank_active;
    // alternate location only in half duplex
    assign alt_sel   = bus.alt_jumper && !bus.full_duplex;
    assign base_ofs  = (alt_sel ? tlc_pkg::VEC_ALT : 16'h0000)
                     + (bus.offset_jumper ? tlc_pkg::VEC_OFFSET : 16'h0000);

    // pending word request, a new condition wins over an ack
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            bus.word_irq <= 1'b0;
        end else begin
            bus.word_irq <= word_cond || (bus.word_irq && !bus.word_ack && bus.word_mask
                            && bus.int_enable && !bus.blank_active);
        end
    end

    // pending end-of-block request
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            bus.eob_irq <= 1'b0;
        end else begin
            bus.eob_irq <= eob_cond || (bus.eob_irq && !bus.eob_ack && bus.eob_mask
                           && bus.int_enable && !bus.blank_active);
        end
    end

    // vector addresses
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            bus.word_vector <= tlc_pkg::VEC_WORD;
            bus.eob_vector  <= tlc_pkg::VEC_EOB;
        end else begin
            bus.word_vector <= tlc_pkg::VEC_WORD + base_ofs;
            bus.eob_vector  <= tlc_pkg::VEC_EOB + base_ofs;
        end
    end

    property p_word_req;
        @(posedge pclk) disable iff (!presetn)
        word_cond |=> bus.word_irq;
    endproperty
    a_word_req: assert property (p_word_req) else $error("word request missing");

    property p_word_nomask;
        @(posedge pclk) disable iff (!presetn)
        !bus.word_mask |=> !bus.word_irq;
    endproperty
    a_word_nomask: assert property (p_word_nomask) else $error("word irq without mask");

    property p_eob_gate;
        @(posedge pclk) disable iff (!presetn)
        $rose(bus.eob_irq) |-> $past(bus.eob_mask && bus.int_enable && bus.echo_in);
    endproperty
    a_eob_gate: assert property (p_eob_gate) else $error("eob irq without cause");

    property p_vec_alt;
        @(posedge pclk) disable iff (!presetn)
        bus.alt_jumper && !bus.full_duplex && !bus.offset_jumper
        |=> bus.word_vector == 16'h0022 && bus.eob_vector == 16'h0026;
    endproperty
    a_vec_alt: assert property (p_vec_alt) else $error("alternate vector wrong");

    property p_vec_fd;
        @(posedge pclk) disable iff (!presetn)
        bus.full_duplex && bus.offset_jumper |=> bus.word_vector == 16'h0102;
    endproperty
    a_vec_fd: assert property (p_vec_fd) else $error("full duplex vector wrong");

endmodule // tlc_irq_unit

// ---- hdl/tlc_top.sv ----
// Decided for this implementation: the APB register port and the register offsets.
`timescale 1ns/100ps
module tlc_top #(
    parameter int unsigned BLANK_CYCLES = tlc_pkg::BLANK_CYCLES
) (
    input  wire logic        pclk,
    input  wire logic        presetn,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [7:0]  paddr,
    input  wire logic [31:0] pwdata,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    input  wire logic        delay_bypass_n,
    input  wire logic        cts,
    input  wire logic        buffer_ready,
    input  wire logic        ctl_busy,
    input  wire logic        rx_char_valid,
    input  wire logic [7:0]  rx_char,
    input  wire logic        int_enable,
    input  wire logic        echo_in,
    input  wire logic        word_ack,
    input  wire logic        eob_ack,
    input  wire logic        alt_loc_jumper,
    input  wire logic        vec_offset_jumper,
    output logic             rts,
    output logic             motor_drive_pos,
    output logic             motor_drive_neg,
    output logic             reader_run_ctl,
    output logic             read_mode,
    output logic             rx_enable,
    output logic             tx_enable,
    output logic             tx_force_mark,
    output logic             tx_char_valid,
    output logic      [7:0]  tx_char,
    output logic             word_irq,
    output logic             eob_irq,
    output logic      [15:0] word_vector,
    output logic      [15:0] eob_vector
);
    tlc_ctl_if cif ();

    logic               motor_on;
    logic               full_duplex;
    logic               auto_echo;
    logic               word_mask;
    logic               eob_mask;
    tlc_pkg::tlc_dir_t  dir;
    tlc_pkg::tlc_rdr_t  rdr;
    tlc_pkg::tlc_cmd_t  cmd;
    logic               wr_access;
    logic               wr_cmd;
    logic               wr_mode;
    logic               rd_setup;
    logic [31:0]        next_rdata;
    logic               addr_ok;
    logic               next_rx_en;
    logic               next_tx_en;

    // address match shared by the read and write paths
    function automatic logic addr_hit(input logic [7:0] a, input logic [7:0] ofs);
        return a == ofs;
    endfunction

    // apb strobes: write lands at the access edge, read data is set up one edge earlier
    assign wr_access = psel && penable && pready && pwrite;
    assign wr_cmd    = wr_access && addr_hit(paddr, tlc_pkg::OFS_CMD);
    assign wr_mode   = wr_access && addr_hit(paddr, tlc_pkg::OFS_MODE);
    assign rd_setup  = psel && !penable;
    assign cmd       = tlc_pkg::tlc_cmd_t'(pwdata[3:0]);
    assign addr_ok   = addr_hit(paddr, tlc_pkg::OFS_CMD) || addr_hit(paddr, tlc_pkg::OFS_MODE)
                    || addr_hit(paddr, tlc_pkg::OFS_STATUS)
                    || addr_hit(paddr, tlc_pkg::OFS_VECTOR);

    // read mux; sense bits go dark while the blanking runs
    always_comb begin
        next_rdata = 32'h0000_0000;
        if (addr_hit(paddr, tlc_pkg::OFS_MODE)) begin
            next_rdata[0] = full_duplex;
        end else if (addr_hit(paddr, tlc_pkg::OFS_STATUS) && !cif.blank_active) begin
            next_rdata[tlc_pkg::ST_BUF_READY] = buffer_ready;
            next_rdata[tlc_pkg::ST_WORD_MASK] = word_mask;
            next_rdata[tlc_pkg::ST_NOT_BUSY]  = !ctl_busy;
            next_rdata[tlc_pkg::ST_CTS]       = cts;
            next_rdata[tlc_pkg::ST_MOTOR_ON]  = motor_on;
            next_rdata[tlc_pkg::ST_FULL_DUP]  = full_duplex;
            next_rdata[tlc_pkg::ST_ECHO]      = auto_echo;
            next_rdata[tlc_pkg::ST_READ_MODE] = (dir == tlc_pkg::DIR_READ);
            next_rdata[tlc_pkg::ST_READER]    = (rdr != tlc_pkg::RDR_IDLE);
            next_rdata[tlc_pkg::ST_EOB_MASK]  = eob_mask;
        end else if (addr_hit(paddr, tlc_pkg::OFS_STATUS)) begin
            next_rdata[tlc_pkg::ST_BLANK]     = 1'b1;
        end else if (addr_hit(paddr, tlc_pkg::OFS_VECTOR)) begin
            next_rdata = {cif.eob_vector, cif.word_vector};
        end
    end

    // apb answer: one access cycle, error on unmapped address
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready  <= 1'b0;
            pslverr <= 1'b0;
            prdata  <= 32'h0000_0000;
        end else begin
            pready  <= rd_setup;
            pslverr <= rd_setup && !addr_ok;
            prdata  <= rd_setup && !pwrite ? next_rdata : 32'h0000_0000;
        end
    end

    // motor flip-flop, the single store behind rts and the drive pair
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            motor_on <= tlc_pkg::RST_MOTOR_ON;
        end else if (wr_cmd && cmd == tlc_pkg::CMD_MOTOR_ON) begin
            motor_on <= 1'b1;
        end else if (wr_cmd && cmd == tlc_pkg::CMD_MOTOR_OFF) begin
            motor_on <= 1'b0;
        end
    end

    // rts and drive outputs are taps of the motor flip-flop
    assign rts             = !motor_on;
    assign motor_drive_pos = motor_on;
    assign motor_drive_neg = !motor_on;

    // duplex mode: mode write loads bit 0, initialize clears
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            full_duplex <= 1'b0;
        end else if (wr_cmd && cmd == tlc_pkg::CMD_INIT) begin
            full_duplex <= 1'b0;
        end else if (wr_mode) begin
            full_duplex <= pwdata[0];
        end
    end

    // direction, auto echo and idle marking
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            dir           <= tlc_pkg::DIR_WRITE;
            auto_echo     <= 1'b0;
            tx_force_mark <= 1'b1;
        end else if (wr_cmd) begin
            tx_force_mark <= (cmd == tlc_pkg::CMD_INIT);
            unique case (cmd)
                tlc_pkg::CMD_ECHO: begin
                    dir       <= tlc_pkg::DIR_READ;
                    auto_echo <= 1'b1;
                end
                tlc_pkg::CMD_KEYBOARD,
                tlc_pkg::CMD_STEP,
                tlc_pkg::CMD_CONT: begin
                    dir <= tlc_pkg::DIR_READ;
                end
                tlc_pkg::CMD_INIT: begin
                    dir       <= tlc_pkg::DIR_WRITE;
                    auto_echo <= 1'b0;
                end
                tlc_pkg::CMD_MOTOR_ON: begin
                    dir <= tlc_pkg::DIR_WRITE;
                end
                default: begin
                    dir <= dir;
                end
            endcase
        end
    end

    // interrupt masks
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            word_mask <= 1'b0;
            eob_mask  <= 1'b0;
        end else if (wr_cmd) begin
            unique case (cmd)
                tlc_pkg::CMD_WORD_EN: word_mask <= 1'b1;
                tlc_pkg::CMD_EOB_EN:  eob_mask  <= 1'b1;
                tlc_pkg::CMD_INIT,
                tlc_pkg::CMD_IRQ_OFF: begin
                    word_mask <= 1'b0;
                    eob_mask  <= 1'b0;
                end
                default: begin
                    word_mask <= word_mask;
                end
            endcase
        end
    end

    // paper tape reader: step stops after one character, continuous runs on
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            rdr <= tlc_pkg::RDR_IDLE;
        end else if (wr_cmd && cmd == tlc_pkg::CMD_STEP) begin
            rdr <= tlc_pkg::RDR_STEP;
        end else if (wr_cmd && cmd == tlc_pkg::CMD_CONT) begin
            rdr <= tlc_pkg::RDR_CONT;
        end else if (wr_cmd && cmd == tlc_pkg::CMD_INIT) begin
            rdr <= tlc_pkg::RDR_IDLE;
        end else begin
            unique case (rdr)
                tlc_pkg::RDR_IDLE: rdr <= tlc_pkg::RDR_IDLE;
                tlc_pkg::RDR_STEP: rdr <= rx_char_valid ? tlc_pkg::RDR_IDLE : tlc_pkg::RDR_STEP;
                tlc_pkg::RDR_CONT: rdr <= tlc_pkg::RDR_CONT;
                default:           rdr <= tlc_pkg::RDR_IDLE;
            endcase
        end
    end

    // registered mode outputs; software flips direction in half duplex
    assign next_rx_en = full_duplex || (dir == tlc_pkg::DIR_READ);
    assign next_tx_en = full_duplex || (dir == tlc_pkg::DIR_WRITE);
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            reader_run_ctl <= 1'b0;
            read_mode      <= 1'b0;
            rx_enable      <= 1'b0;
            tx_enable      <= 1'b1;
        end else begin
            reader_run_ctl <= (rdr != tlc_pkg::RDR_IDLE);
            read_mode      <= (dir == tlc_pkg::DIR_READ);
            rx_enable      <= next_rx_en;
            tx_enable      <= next_tx_en;
        end
    end

    // auto echo of each received character
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            tx_char_valid <= 1'b0;
            tx_char       <= 8'h00;
        end else begin
            tx_char_valid <= auto_echo && rx_char_valid;
            if (auto_echo && rx_char_valid) begin
                tx_char <= rx_char;
            end
        end
    end

    // links to the timer and the interrupt unit
    assign cif.blank_load    = wr_cmd && cmd == tlc_pkg::CMD_MOTOR_ON;
    assign cif.bypass_n      = delay_bypass_n;
    assign cif.word_mask     = word_mask;
    assign cif.eob_mask      = eob_mask;
    assign cif.int_enable    = int_enable;
    assign cif.buffer_ready  = buffer_ready;
    assign cif.echo_in       = echo_in;
    assign cif.word_ack      = word_ack;
    assign cif.eob_ack       = eob_ack;
    assign cif.full_duplex   = full_duplex;
    assign cif.alt_jumper    = alt_loc_jumper;
    assign cif.offset_jumper = vec_offset_jumper;
    assign word_irq          = cif.word_irq;
    assign eob_irq           = cif.eob_irq;
    assign word_vector       = cif.word_vector;
    assign eob_vector        = cif.eob_vector;

    tlc_blank_timer #(
        .CYCLES (BLANK_CYCLES)
    ) u_timer (
        .pclk    (pclk),
        .presetn (presetn),
        .bus     (cif.timer)
    );

    tlc_irq_unit u_irq (
        .pclk    (pclk),
        .presetn (presetn),
        .bus     (cif.irq)
    );

    property p_motor_on;
        @(posedge pclk) disable iff (!presetn)
        wr_cmd && cmd == tlc_pkg::CMD_MOTOR_ON |=> !rts && motor_drive_pos && !motor_drive_neg;
    endproperty
    a_motor_on: assert property (p_motor_on) else $error("motor on left rts high");

    property p_motor_off;
        @(posedge pclk) disable iff (!presetn)
        wr_cmd && cmd == tlc_pkg::CMD_MOTOR_OFF |=> rts && !motor_drive_pos;
    endproperty
    a_motor_off: assert property (p_motor_off) else $error("motor off left rts low");

    property p_half_duplex;
        @(posedge pclk) disable iff (!presetn)
        !$past(full_duplex) |-> !(rx_enable && tx_enable);
    endproperty
    a_half_duplex: assert property (p_half_duplex) else $error("both directions on");

    property p_echo;
        @(posedge pclk) disable iff (!presetn)
        auto_echo && rx_char_valid |=> tx_char_valid && tx_char == $past(rx_char);
    endproperty
    a_echo: assert property (p_echo) else $error("character not echoed");

    property p_blank_sense;
        @(posedge pclk) disable iff (!presetn)
        rd_setup && !pwrite && addr_hit(paddr, tlc_pkg::OFS_STATUS) && cif.blank_active
        |=> prdata[tlc_pkg::ST_CTS] == 1'b0 && prdata[tlc_pkg::ST_BLANK];
    endproperty
    a_blank_sense: assert property (p_blank_sense) else $error("sense seen in blanking");

    property p_cts;
        @(posedge pclk) disable iff (!presetn)
        rd_setup && !pwrite && addr_hit(paddr, tlc_pkg::OFS_STATUS) && !cif.blank_active
        |=> prdata[tlc_pkg::ST_CTS] == $past(cts);
    endproperty
    a_cts: assert property (p_cts) else $error("clear to send misreported");

    property p_init;
        @(posedge pclk) disable iff (!presetn)
        wr_cmd && cmd == tlc_pkg::CMD_INIT
        |=> !full_duplex && !word_mask && !eob_mask && tx_force_mark ##1 !read_mode;
    endproperty
    a_init: assert property (p_init) else $error("initialize incomplete");

endmodule // tlc_top

// ---- bench/tlc_term_model.sv ----
`timescale 1ns/100ps
// terminal on crossed control lines, sends on request, keeps what comes back
module tlc_term_model (
    input  wire logic       pclk,
    input  wire logic       rts,
    input  wire logic       send,
    input  wire logic [7:0] ch,
    input  wire logic       tx_char_valid,
    input  wire logic [7:0] tx_char,
    output logic            cts,
    output logic            rx_char_valid,
    output logic      [7:0] rx_char,
    output logic      [7:0] echoed
);
    // our clear-to-send follows the controller request line
    assign cts = rts;
    initial begin
        rx_char_valid = 1'b0;
        rx_char = 8'h00;
        echoed = 8'h00;
    end
    // character strobe, data line toggles when idle
    always @(posedge pclk) begin
        rx_char_valid <= send;
        rx_char <= send ? ch : ~rx_char;
        if (tx_char_valid) echoed <= tx_char;
    end
endmodule // tlc_term_model

// ---- bench/terminal_link_control_tb.sv ----
`timescale 1ns/100ps
module terminal_link_control_tb;
    logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
    logic [7:0] paddr = 8'h00, ch = 8'h00, rx_char, echoed;
    logic [31:0] pwdata = 32'h0, prdata, rd;
    logic pready, pslverr, er, byp_n = 1, bufr = 0, busy = 0, ien = 0, echo = 0;
    logic wack = 0, eack = 0, alt = 0, ofs = 0, send = 0, cts, rxv, rts, mpos, mneg;
    logic rdr, rmode, rxe, txe, mark, txv, wirq, eirq;
    logic [7:0] txc;
    logic [15:0] wv, ev;
    int fail_count = 0, n_compared = 0;
    tlc_top #(.BLANK_CYCLES(20)) tlc_top_i (.pclk(pclk), .presetn(presetn), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .delay_bypass_n(byp_n), .cts(cts),
        .buffer_ready(bufr), .ctl_busy(busy), .rx_char_valid(rxv), .rx_char(rx_char),
        .int_enable(ien), .echo_in(echo), .word_ack(wack), .eob_ack(eack),
        .alt_loc_jumper(alt), .vec_offset_jumper(ofs), .rts(rts), .motor_drive_pos(mpos),
        .motor_drive_neg(mneg), .reader_run_ctl(rdr), .read_mode(rmode), .rx_enable(rxe),
        .tx_enable(txe), .tx_force_mark(mark), .tx_char_valid(txv), .tx_char(txc),
        .word_irq(wirq), .eob_irq(eirq), .word_vector(wv), .eob_vector(ev));
    tlc_term_model tlc_term_model_i (.pclk(pclk), .rts(rts), .send(send), .ch(ch),
        .tx_char_valid(txv), .tx_char(txc), .cts(cts), .rx_char_valid(rxv),
        .rx_char(rx_char), .echoed(echoed));
    // clock
    initial begin
        forever #5 pclk = ~pclk;
    end
    // one apb transfer, waits for pready in the access phase
    task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge pclk);
        psel <= 1; penable <= 0; pwrite <= w; paddr <= a; pwdata <= d;
        @(posedge pclk);
        penable <= 1;
        do @(posedge pclk); while (pready !== 1'b1);
        rd = prdata;
        er = pslverr;
        psel <= 0; penable <= 0;
    endtask
    task automatic cmd(input tlc_pkg::tlc_cmd_t c);
        xfer(1, tlc_pkg::OFS_CMD, {28'h0, c});
        repeat (3) @(posedge pclk);
    endtask
    task automatic chk(input logic [31:0] g, input logic [31:0] e);
        n_compared++;
        if (g !== e) begin
            fail_count++;
            $display("Error %0t: got %h expected %h", $time, g, e);
        end
    endtask
    task automatic end_sim;
        if (fail_count == 0 && n_compared > 0) $display("All tests passed");
        else $display("Some tests failed");
        $finish;
    endtask
    // watchdog
    initial begin
        #100us;
        fail_count++;
        end_sim();
    end
    // main sequence
    initial begin
        repeat (5) @(posedge pclk);
        presetn <= 1;
        chk({rts, mpos, mneg}, 3'b010);
        xfer(0, tlc_pkg::OFS_VECTOR, 0); chk(rd, 32'h00060002);
        xfer(0, tlc_pkg::OFS_STATUS, 0); chk(rd, 32'h14);
        cmd(tlc_pkg::CMD_MOTOR_OFF); chk({rts, mpos, mneg}, 3'b101);
        busy <= 1;
        xfer(0, tlc_pkg::OFS_STATUS, 0); chk(rd, 32'h08);
        busy <= 0;
        cmd(tlc_pkg::CMD_MOTOR_ON); chk(rts, 0);
        xfer(0, tlc_pkg::OFS_STATUS, 0); chk(rd, 32'h40);
        repeat (25) @(posedge pclk);
        xfer(0, tlc_pkg::OFS_STATUS, 0); chk(rd, 32'h14);
        byp_n <= 0;
        xfer(1, tlc_pkg::OFS_CMD, {28'h0, tlc_pkg::CMD_MOTOR_ON});
        xfer(0, tlc_pkg::OFS_STATUS, 0); chk(rd, 32'h14);
        cmd(tlc_pkg::CMD_ECHO); chk({rmode, rxe, txe}, 3'b110);
        send <= 1; ch <= 8'ha5;
        @(posedge pclk) send <= 0;
        repeat (4) @(posedge pclk);
        chk(echoed, 8'ha5);
        ien <= 1; bufr <= 1;
        cmd(tlc_pkg::CMD_WORD_EN); chk(wirq, 1);
        bufr <= 0;
        wack <= 1;
        @(posedge pclk) wack <= 0;
        @(posedge pclk) bufr <= 1;
        chk(wirq, 0);
        cmd(tlc_pkg::CMD_IRQ_OFF); chk(wirq, 0);
        echo <= 1;
        cmd(tlc_pkg::CMD_EOB_EN); chk(eirq, 1);
        echo <= 0;
        eack <= 1;
        @(posedge pclk) eack <= 0;
        @(posedge pclk) echo <= 1;
        chk(eirq, 0);
        cmd(tlc_pkg::CMD_CONT); chk(rdr, 1);
        cmd(tlc_pkg::CMD_INIT); chk({rdr, rmode, mark, eirq}, 4'b0010);
        echo <= 0;
        cmd(tlc_pkg::CMD_KEYBOARD); chk(rmode, 1);
        cmd(tlc_pkg::CMD_STEP); chk(rdr, 1);
        send <= 1;
        ch <= 8'h3c;
        @(posedge pclk) send <= 0;
        repeat (3) @(posedge pclk);
        chk(rdr, 0);
        alt <= 1;
        xfer(0, tlc_pkg::OFS_VECTOR, 0); chk(rd, 32'h00260022);
        ofs <= 1;
        xfer(0, tlc_pkg::OFS_VECTOR, 0); chk(rd, 32'h01260122);
        xfer(1, tlc_pkg::OFS_MODE, 1);
        xfer(0, tlc_pkg::OFS_VECTOR, 0); chk(rd, 32'h01060102);
        chk({ev, wv}, 32'h01060102);
        chk({rxe, txe}, 2'b11);
        xfer(0, 8'h10, 0); chk(er, 1);
        chk(rd, 0);
        cmd(tlc_pkg::CMD_MOTOR_OFF);
        presetn <= 0;
        @(posedge pclk) presetn <= 1;
        chk({rts, mpos, mneg}, 3'b010);
        end_sim();
    end
endmodule // terminal_link_control_tb
